/* File: verilog/exec_cfg.svh */
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH

`define CFG_PC_W 15
`define CFG_DATA_W 8
`define CFG_FADDR_W 7
`define CFG_REG_DEPTH 128
`define CFG_STACK_AW 4
`define CFG_STACK_DEPTH 16
`define CFG_WDT_W 8
`define CFG_ZERO8 8'h00
`define CFG_ONE8 8'h01
`define CFG_PC_RESET 15'h0000
`define CFG_PC_ONE 15'h0001
`define CFG_SP_RESET 4'h0
`define CFG_SP_ONE 4'h1
`define CFG_WDT_PRE_MAX 8'hff
`define CFG_WDT_PRE_ONE 8'h01
`define CFG_WDT_LIMIT 8'hff
`define CFG_WDT_ONE 8'h01

`endif

/* File: verilog/exec_pkg.sv */
package exec_pkg;

   typedef enum logic [2:0] {
      op_nop,
      clear_watchdog_op,
      call_via_accumulator_op,
      complement_register_op,
      clear_register_op,
      decrement_register_op,
      clear_accumulator_op,
      decrement_skip_nil_op
   } op_e;

   typedef enum logic [1:0] {
      st_idle,
      st_exec,
      st_call_push,
      st_call_load
   } exec_state_e;

endpackage

/* File: verilog/word_mem.sv */
`timescale 1ns/10ps
`default_nettype none
// simple one-write one-read memory, read data registered
module word_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 128,
   parameter int AW = 7
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);

   logic [WIDTH-1:0] mem_r [DEPTH];

   // storage has no reset; contents are undefined until written
   always_ff @(posedge clock) begin
      if (wr_en) begin
         mem_r[wr_addr] <= wr_data;
      end
   end

   // read is one clock late, same address write not bypassed
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rd_data <= '0;
      end else begin
         rd_data <= mem_r[rd_addr];
      end
   end

endmodule
`default_nettype wire

/* File: verilog/watchdog.sv */
`timescale 1ns/10ps
`default_nettype none
`include "exec_cfg.svh"
// prescaled watchdog counter with synchronous clear
module watchdog (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic clear,
   output logic [`CFG_WDT_W-1:0] count,
   output logic [`CFG_WDT_W-1:0] prescale,
   output logic expired
);

   wire pre_wrap = (prescale == `CFG_WDT_PRE_MAX);
   wire cnt_wrap = (count == `CFG_WDT_LIMIT);

   // prescaler is the slow-rate divider; count only moves on its wrap
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         prescale <= `CFG_ZERO8;
         count <= `CFG_ZERO8;
      end else if (clear) begin
         prescale <= `CFG_ZERO8;
         count <= `CFG_ZERO8;
      end else begin
         prescale <= pre_wrap ? `CFG_ZERO8 : prescale + `CFG_WDT_PRE_ONE;
         if (pre_wrap) begin
            count <= cnt_wrap ? `CFG_ZERO8 : count + `CFG_WDT_ONE;
         end
      end
   end

   // one-cycle pulse when the counter rolls over
   assign expired = pre_wrap & cnt_wrap & ~clear;

endmodule
`default_nettype wire

/* File: verilog/exec_core.sv */
`timescale 1ns/10ps
`default_nettype none
`include "exec_cfg.svh"
// executes the clear, call-via-accumulator and decrement group
module exec_core (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic instr_valid,
   output logic instr_ready,
   input wire exec_pkg::op_e op,
   input wire logic [`CFG_FADDR_W-1:0] f_addr,
   input wire logic dest_sel,
   input wire logic [`CFG_FADDR_W-1:0] pc_upper_latch,
   input wire logic sleep_req,
   output logic [`CFG_PC_W-1:0] pc,
   output logic [`CFG_DATA_W-1:0] accum,
   output logic zero_flag,
   output logic timeout_n,
   output logic sleep_entered_n,
   output logic skip_pending,
   output logic [`CFG_PC_W-1:0] stack_head,
   output logic [`CFG_STACK_AW-1:0] stack_ptr,
   output logic [`CFG_WDT_W-1:0] watchdog_counter,
   output logic [`CFG_WDT_W-1:0] watchdog_prescale
);
   import exec_pkg::*;

   exec_state_e state_r, state_nxt;
   op_e op_r;
   logic [`CFG_FADDR_W-1:0] f_r;
   logic d_r;
   logic [`CFG_PC_W-1:0] pc_r;
   logic [`CFG_DATA_W-1:0] accum_r;
   logic zero_r, timeout_n_r, sleep_n_r, skip_r;
   logic [`CFG_STACK_AW-1:0] sp_r;
   logic [`CFG_DATA_W-1:0] reg_rd;
   logic wdt_expired;

   // handshake and phase decode
   wire accept = instr_valid & instr_ready;
   wire in_exec = (state_r == st_exec);
   wire discard = accept & skip_r;
   wire is_comp = (op_r == complement_register_op);
   wire is_dec = (op_r == decrement_register_op);
   wire is_dskip = (op_r == decrement_skip_nil_op);
   wire is_clear_register_op = (op_r == clear_register_op);
   wire is_clear_accumulator_op = (op_r == clear_accumulator_op);
   wire is_wdt = (op_r == clear_watchdog_op);
   wire is_call = (op_r == call_via_accumulator_op);

   // datapath results
   wire [`CFG_DATA_W-1:0] comp_val = ~reg_rd;
   wire [`CFG_DATA_W-1:0] dec_val = reg_rd - `CFG_ONE8;
   wire [`CFG_DATA_W-1:0] result =
      is_comp ? comp_val : ((is_dec | is_dskip) ? dec_val : `CFG_ZERO8);
   wire routed = is_comp | is_dec | is_dskip;
   // destination bit picks accumulator (0) or register (1)
   wire wr_reg = in_exec & ((routed & d_r) | is_clear_register_op);
   wire wr_acc = in_exec & ((routed & ~d_r) | is_clear_accumulator_op);
   // decrement-skip leaves zero alone, only the skip looks at its result
   wire upd_zero = in_exec & (is_comp | is_dec);
   wire set_zero = in_exec & (is_clear_register_op | is_clear_accumulator_op);
   wire take_skip = in_exec & is_dskip & (dec_val == `CFG_ZERO8);
   wire wdt_clear = in_exec & is_wdt;
   wire call_push = (state_r == st_call_push);
   wire call_load = (state_r == st_call_load);

   // state sequence: one instruction cycle is accept plus execute
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         st_idle: begin
            if (accept) begin
               state_nxt = st_exec;
            end
         end
         st_exec: begin
            state_nxt = is_call ? st_call_push : st_idle;
         end
         st_call_push: begin
            state_nxt = st_call_load;
         end
         st_call_load: begin
            state_nxt = st_idle;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= st_idle;
      end else begin
         state_r <= state_nxt;
      end
   end

   // latch the decoded instruction; a skipped one becomes a no-op
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         op_r <= op_nop;
         f_r <= '0;
         d_r <= 1'b0;
      end else if (accept) begin
         op_r <= discard ? op_nop : op;
         f_r <= f_addr;
         d_r <= dest_sel;
      end
   end

   // pc steps on every accept, so it already holds the return address
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pc_r <= `CFG_PC_RESET;
      end else if (call_load) begin
         pc_r <= {pc_upper_latch, accum_r};
      end else if (accept) begin
         pc_r <= pc_r + `CFG_PC_ONE;
      end
   end

   // return stack pointer; sixteen levels wrap silently
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         sp_r <= `CFG_SP_RESET;
      end else if (call_push) begin
         sp_r <= sp_r + `CFG_SP_ONE;
      end
   end

   // accumulator and zero flag; call never touches either
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         accum_r <= `CFG_ZERO8;
         zero_r <= 1'b0;
      end else begin
         if (wr_acc) begin
            accum_r <= result;
         end
         if (set_zero) begin
            zero_r <= 1'b1;
         end else if (upd_zero) begin
            zero_r <= (result == `CFG_ZERO8);
         end
      end
   end

   // skip flag: set by a decrement-skip that reaches zero, consumed by the next accept
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         skip_r <= 1'b0;
      end else if (take_skip) begin
         skip_r <= 1'b1;
      end else if (accept) begin
         skip_r <= 1'b0;
      end
   end

   // status bits: sleep request wins over the clear instruction, but a clear masks a same-cycle watchdog expiry
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         timeout_n_r <= 1'b1;
         sleep_n_r <= 1'b1;
      end else begin
         if (wdt_expired) begin
            timeout_n_r <= 1'b0;
         end else if (wdt_clear) begin
            timeout_n_r <= 1'b1;
         end
         if (sleep_req) begin
            sleep_n_r <= 1'b0;
         end else if (wdt_clear) begin
            sleep_n_r <= 1'b1;
         end
      end
   end

   // register file, read issued at accept, data ready in execute
   word_mem #(
      .WIDTH(`CFG_DATA_W),
      .DEPTH(`CFG_REG_DEPTH),
      .AW(`CFG_FADDR_W)
   ) u_regs (
      .clock(clock),
      .rst_b(rst_b),
      .wr_en(wr_reg),
      .wr_addr(f_r),
      .wr_data(result),
      .rd_addr(f_addr),
      .rd_data(reg_rd)
   );

   // return stack; head shows the last pushed address a clock later
   word_mem #(
      .WIDTH(`CFG_PC_W),
      .DEPTH(`CFG_STACK_DEPTH),
      .AW(`CFG_STACK_AW)
   ) u_stack (
      .clock(clock),
      .rst_b(rst_b),
      .wr_en(call_push),
      .wr_addr(sp_r),
      .wr_data(pc_r),
      .rd_addr(sp_r - `CFG_SP_ONE),
      .rd_data(stack_head)
   );

   watchdog u_wdt (
      .clock(clock),
      .rst_b(rst_b),
      .clear(wdt_clear),
      .count(watchdog_counter),
      .prescale(watchdog_prescale),
      .expired(wdt_expired)
   );

   assign instr_ready = (state_r == st_idle);
   assign pc = pc_r;
   assign accum = accum_r;
   assign zero_flag = zero_r;
   assign timeout_n = timeout_n_r;
   assign sleep_entered_n = sleep_n_r;
   assign skip_pending = skip_r;
   assign stack_ptr = sp_r;

endmodule
`default_nettype wire

/* File: test/reg_model.sv */
`timescale 1ns/10ps
`default_nettype none
// shadow of the internal register file; starts unknown, as the real array does
module reg_model;
   logic [7:0] mem [128];
endmodule
`default_nettype wire

/* File: test/exec_chk.sv */
`timescale 1ns/10ps
`default_nettype none
`include "exec_cfg.svh"
// watches accepted instructions and the state they must leave behind
module exec_chk (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic instr_valid,
   input wire logic instr_ready,
   input wire exec_pkg::op_e op,
   input wire logic dest_sel,
   input wire logic [`CFG_FADDR_W-1:0] pc_upper_latch,
   input wire logic sleep_req,
   input wire logic [`CFG_PC_W-1:0] pc,
   input wire logic [`CFG_DATA_W-1:0] accum,
   input wire logic zero_flag,
   input wire logic timeout_n,
   input wire logic sleep_entered_n,
   input wire logic skip_pending,
   input wire logic [`CFG_PC_W-1:0] stack_head,
   input wire logic [`CFG_WDT_W-1:0] watchdog_counter,
   input wire logic [`CFG_WDT_W-1:0] watchdog_prescale
);
   import exec_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   // a discarded instruction has none of its own effects
   wire logic take = instr_valid && instr_ready;
   wire logic run = take && !skip_pending;
   sequence call_take;
      run && op == call_via_accumulator_op;
   endsequence
   sequence call_busy;
      !instr_ready [*3] ##1 instr_ready;
   endsequence
   wd_zero_a: assert property (run && op == clear_watchdog_op |-> ##2
      watchdog_counter == 8'h00 && watchdog_prescale == 8'h00) else $error("watchdog kept");
   status_set_a: assert property (run && op == clear_watchdog_op ##1 !sleep_req |=>
      timeout_n && sleep_entered_n) else $error("status bits not set");
   call_push_a: assert property (call_take |-> ##4
      stack_head == $past(pc, 4) + 15'h0001) else $error("bad return address");
   call_load_a: assert property (call_take |-> ##4
      pc == {$past(pc_upper_latch), accum}) else $error("bad call target");
   call_len_a: assert property (call_take |=> call_busy) else $error("call length");
   call_flag_a: assert property (call_take |=> $stable(zero_flag) [*4])
      else $error("call moved zero flag");
   clr_zero_a: assert property (run && op == clear_register_op |-> ##2 zero_flag)
      else $error("clear left zero low");
   dec_zero_a: assert property (run && op == decrement_register_op && !dest_sel |-> ##2
      zero_flag == (accum == 8'h00)) else $error("zero flag wrong");
   skip_flag_a: assert property (run && op == decrement_skip_nil_op |-> ##2
      zero_flag == $past(zero_flag, 2)) else $error("skip moved zero flag");
   skip_drop_a: assert property (take && skip_pending |-> ##2
      accum == $past(accum, 2) && !skip_pending) else $error("skipped op took effect");
   one_cyc_a: assert property (run && op != call_via_accumulator_op |=>
      !instr_ready ##1 instr_ready) else $error("op length");
endmodule
bind exec_core exec_chk chk (.*);
`default_nettype wire

/* File: test/clear_call_decrement_exec_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module clear_call_decrement_exec_tb_top;
   import exec_pkg::*;
   logic clock, instr_ready, zero_flag, timeout_n, sleep_entered_n, skip_pending;
   logic rst_b = 1'b0;
   logic instr_valid = 1'b0;
   logic dest_sel = 1'b0;
   logic sleep_req = 1'b0;
   op_e op = op_nop;
   logic [6:0] f_addr = 7'h00;
   logic [6:0] pc_upper_latch = 7'h2b;
   logic [14:0] pc, stack_head, epc;
   logic [7:0] accum, watchdog_counter, watchdog_prescale, ea;
   logic [3:0] stack_ptr;
   logic ez, sk;
   int n_errors = 0;
   int n_checks = 0;
   int n_wait = 0;
   reg_model rm ();
   exec_core DUT (
      .clock(clock),
      .rst_b(rst_b),
      .instr_valid(instr_valid),
      .instr_ready(instr_ready),
      .op(op),
      .f_addr(f_addr),
      .dest_sel(dest_sel),
      .pc_upper_latch(pc_upper_latch),
      .sleep_req(sleep_req),
      .pc(pc),
      .accum(accum),
      .zero_flag(zero_flag),
      .timeout_n(timeout_n),
      .sleep_entered_n(sleep_entered_n),
      .skip_pending(skip_pending),
      .stack_head(stack_head),
      .stack_ptr(stack_ptr),
      .watchdog_counter(watchdog_counter),
      .watchdog_prescale(watchdog_prescale)
   );
   // free-running clock
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   task automatic cmp(string nm, logic [15:0] e, logic [15:0] s);
      n_checks++;
      if (s !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // offer one instruction, hold it until taken, then count edges until ready again
   task automatic issue(op_e o, logic [6:0] f, logic d);
      int n;
      @(posedge clock);
      instr_valid <= 1'b1;
      op <= o;
      f_addr <= f;
      dest_sel <= d;
      n = 0;
      #1;
      // ready only moves on an edge, so seen high here means taken at the next one
      while (instr_ready !== 1'b1 && n < 8) begin
         @(posedge clock);
         #1;
         n++;
      end
      @(posedge clock);
      instr_valid <= 1'b0;
      n_wait = 0;
      do begin
         @(posedge clock);
         #1;
         n_wait++;
      end while (instr_ready !== 1'b1 && n_wait < 8);
      if (n == 8 || instr_ready !== 1'b1) begin
         n_errors++;
         tally_and_finish();
      end
   endtask
   task automatic put(logic [7:0] v, logic d, logic [6:0] f, logic z);
      if (d) rm.mem[f] = v;
      else ea = v;
      if (z) ez = (v == 8'h00);
   endtask
   // expected result from the shadow file, then issue and compare
   task automatic run(op_e o, logic [6:0] f, logic d);
      logic [7:0] r;
      logic nsk;
      logic [15:0] ecyc;
      r = rm.mem[f];
      // call holds the port two instruction cycles, all else one
      ecyc = (o == call_via_accumulator_op && !sk) ? 16'h0003 : 16'h0001;
      nsk = !sk && o == decrement_skip_nil_op && r == 8'h01;
      epc = epc + 15'h0001;
      if (!sk) begin
         case (o)
            complement_register_op: put(~r, d, f, 1'b1);
            decrement_register_op: put(r - 8'h01, d, f, 1'b1);
            decrement_skip_nil_op: put(r - 8'h01, d, f, 1'b0);
            clear_register_op: put(8'h00, 1'b1, f, 1'b1);
            clear_accumulator_op: put(8'h00, 1'b0, f, 1'b1);
            call_via_accumulator_op: epc = {pc_upper_latch, ea};
            default: ;
         endcase
      end
      sk = nsk;
      issue(o, f, d);
      cmp("accum", 16'(ea), 16'(accum));
      cmp("zero_flag", 16'(ez), 16'(zero_flag));
      cmp("pc", 16'(epc), 16'(pc));
      cmp("skip_pending", 16'(sk), 16'(skip_pending));
      cmp("cycles", ecyc, 16'(n_wait));
   endtask
   task automatic t_regs();
      run(clear_register_op, 7'h05, 1'b0);
      run(decrement_register_op, 7'h05, 1'b0);
      run(decrement_register_op, 7'h05, 1'b1);
      run(complement_register_op, 7'h05, 1'b0);
      run(clear_register_op, 7'h7f, 1'b1);
      run(complement_register_op, 7'h7f, 1'b1);
      run(decrement_register_op, 7'h7f, 1'b0);
   endtask
   // build a one, skip on it, then repeat without a skip
   task automatic t_skip();
      run(clear_register_op, 7'h06, 1'b1);
      run(decrement_register_op, 7'h06, 1'b1);
      run(decrement_register_op, 7'h06, 1'b1);
      run(complement_register_op, 7'h06, 1'b1);
      run(decrement_skip_nil_op, 7'h06, 1'b1);
      run(clear_accumulator_op, 7'h00, 1'b0);
      run(decrement_skip_nil_op, 7'h06, 1'b0);
      run(clear_accumulator_op, 7'h00, 1'b0);
   endtask
   task automatic t_call();
      logic [14:0] ret;
      run(decrement_register_op, 7'h06, 1'b0);
      ret = epc + 15'h0001;
      run(call_via_accumulator_op, 7'h00, 1'b0);
      cmp("stack_head", 16'(ret), 16'(stack_head));
      cmp("stack_ptr", 16'h0001, 16'(stack_ptr));
      // second call with a new upper latch and zero set, so flags must hold
      @(posedge clock);
      pc_upper_latch <= 7'h51;
      run(clear_accumulator_op, 7'h00, 1'b0);
      ret = epc + 15'h0001;
      run(call_via_accumulator_op, 7'h00, 1'b0);
      cmp("stack_head", 16'(ret), 16'(stack_head));
      cmp("stack_ptr", 16'h0002, 16'(stack_ptr));
   endtask
   // let the watchdog run out, enter sleep, then clear both
   task automatic t_wdog();
      int n;
      n = 0;
      // full rollover is about 64k clocks, bounded so a dead counter ends the run
      while (timeout_n !== 1'b0 && n < 70000) begin
         @(posedge clock);
         #1;
         n++;
      end
      cmp("timeout_n", 16'h0000, 16'(timeout_n));
      if (timeout_n !== 1'b0) begin
         tally_and_finish();
      end
      @(posedge clock);
      sleep_req <= 1'b1;
      @(posedge clock);
      sleep_req <= 1'b0;
      @(posedge clock);
      #1;
      cmp("sleep_entered_n", 16'h0000, 16'(sleep_entered_n));
      run(clear_watchdog_op, 7'h00, 1'b0);
      cmp("watchdog_counter", 16'h0000, 16'(watchdog_counter));
      cmp("watchdog_prescale", 16'h0000, 16'(watchdog_prescale));
      cmp("status", 16'h0003, 16'({timeout_n, sleep_entered_n}));
   endtask
   // main sequence
   initial begin
      ea = 8'h00;
      ez = 1'b0;
      sk = 1'b0;
      epc = 15'h0000;
      repeat (6) @(posedge clock);
      rst_b <= 1'b1;
      t_regs();
      t_skip();
      t_call();
      t_wdog();
      tally_and_finish();
   end
endmodule
`default_nettype wire
